// >>> spt_self_test.sv
// spt_self_test: per-lane prbs bit-error test and short transport test
// assumes: lane bits and converter samples come from logic on i_mclk
// Function
// - three-bit lane selector chooses whose error count is read back
// - pattern field: 00 prbs7, 01 prbs15, 10 prbs31
// - run bit one runs the bit-error test, zero stops it
// - clear bit one holds checker state machine and counters in reset
// - 24-bit error limit split over low, mid and high byte registers
// - 24-bit read-only error total of selected lane, three bytes ascending
// - lane pass flag follows whether its error count is below the limit while a test runs
// - eight-bit read-only pass status, one bit per lane, 0xFF after reset
// - two-bit sample selector picks which sample is checked
// - two-bit converter selector picks which converter is checked
// - transport result clear bit one clears the stored result
// - transport comparison happens only while its enable bit is one
// - low byte of the expected sample sits in a writable register
// - compare against the sample straight from the link receiver output
// - high byte of the expected sample sits in a second register
// - result bit reads zero on match, one on mismatch
// - one enable bit per lane gates each lane's prbs check
`timescale 1ns/100ps

module spt_self_test #(
	parameter int LANES = 8
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic [11:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	input wire spt_pkg::spt_lane_in_s i_lane,
	input wire spt_pkg::spt_tpl_in_s i_tpl,
	output logic [7:0] o_lane_pass_flags,
	output logic o_transport_mismatch
);

	// ****************************************************************
	// register write decode
	// ****************************************************************
	logic [7:0] lane_bert_enables_q;
	logic [7:0] prbs_ctrl_q;
	logic [23:0] bert_error_limit_q;
	logic [7:0] tpl_ctrl_q;
	logic [15:0] expected_sample_q;
	logic transport_mismatch_q;
	logic [LANES-1:0] pass_q;
	logic [7:0] rdata_q;

	// one strobe per writable register
	wire wr_en = i_reg_wr && (i_reg_addr == spt_pkg::OFF_LANE_BERT_EN);
	wire wr_ctrl = i_reg_wr && (i_reg_addr == spt_pkg::OFF_PRBS_CTRL);
	wire wr_thr_low = i_reg_wr && (i_reg_addr == spt_pkg::OFF_THR_LOW);
	wire wr_thr_mid = i_reg_wr && (i_reg_addr == spt_pkg::OFF_THR_MID);
	wire wr_thr_high = i_reg_wr && (i_reg_addr == spt_pkg::OFF_THR_HIGH);
	wire wr_tpl = i_reg_wr && (i_reg_addr == spt_pkg::OFF_TPL_CTRL);
	wire wr_ref_low = i_reg_wr && (i_reg_addr == spt_pkg::OFF_REF_LOW);
	wire wr_ref_high = i_reg_wr && (i_reg_addr == spt_pkg::OFF_REF_HIGH);

	// named control fields
	wire bert_clear = prbs_ctrl_q[spt_pkg::CTRL_CLEAR_BIT];
	wire bert_run = prbs_ctrl_q[spt_pkg::CTRL_RUN_BIT];
	wire [1:0] pattern_selector = prbs_ctrl_q[spt_pkg::CTRL_PAT_LSB +: 2];
	wire [2:0] error_lane_selector = prbs_ctrl_q[spt_pkg::CTRL_LANE_LSB +: 3];
	wire transport_check_enable = tpl_ctrl_q[spt_pkg::TPL_EN_BIT];
	wire transport_result_clear = tpl_ctrl_q[spt_pkg::TPL_CLR_BIT];
	wire [1:0] converter_selector = tpl_ctrl_q[spt_pkg::TPL_CONV_LSB +: 2];
	wire [1:0] sample_selector = tpl_ctrl_q[spt_pkg::TPL_SAMP_LSB +: 2];

	// ****************************************************************
	// writable registers
	// ****************************************************************

	// per-lane enables
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lane_bert_enables_q <= spt_pkg::RST_BYTE;
		end else if (wr_en) begin
			lane_bert_enables_q <= i_reg_wdata;
		end
	end

	// prbs control; bit 7 is reserved and stays zero
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			prbs_ctrl_q <= spt_pkg::RST_BYTE;
		end else if (wr_ctrl) begin
			prbs_ctrl_q <= i_reg_wdata & spt_pkg::CTRL_WR_MASK;
		end
	end

	// error limit, one byte lane per register
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			bert_error_limit_q <= {3{spt_pkg::RST_BYTE}};
		end else begin
			if (wr_thr_low) begin
				bert_error_limit_q[7:0] <= i_reg_wdata;
			end
			if (wr_thr_mid) begin
				bert_error_limit_q[15:8] <= i_reg_wdata;
			end
			if (wr_thr_high) begin
				bert_error_limit_q[23:16] <= i_reg_wdata;
			end
		end
	end

	// transport control; bits 7:6 reserved
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tpl_ctrl_q <= spt_pkg::RST_BYTE;
		end else if (wr_tpl) begin
			tpl_ctrl_q <= i_reg_wdata & spt_pkg::TPL_WR_MASK;
		end
	end

	// expected sample, low and high halves
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			expected_sample_q <= {2{spt_pkg::RST_BYTE}};
		end else begin
			if (wr_ref_low) begin
				expected_sample_q[7:0] <= i_reg_wdata;
			end
			if (wr_ref_high) begin
				expected_sample_q[15:8] <= i_reg_wdata;
			end
		end
	end

	// ****************************************************************
	// prbs test sequencer
	// ****************************************************************
	spt_pkg::spt_state_e st_q;
	spt_pkg::spt_state_e st_d;
	logic [4:0] seed_q;
	logic [4:0] seed_d;

	// the checkers self-seed from the incoming stream, so the first bits
	// after a start would compare against garbage; they are not counted
	always_comb begin
		st_d = st_q;
		case (st_q)
			spt_pkg::ST_IDLE: begin
				if (bert_run) begin
					st_d = spt_pkg::ST_SEED;
				end
			end
			spt_pkg::ST_SEED: begin
				if (!bert_run) begin
					st_d = spt_pkg::ST_IDLE;
				end else if (i_lane.valid && (seed_q == spt_pkg::SEED_LAST)) begin
					st_d = spt_pkg::ST_CHECK;
				end
			end
			spt_pkg::ST_CHECK: begin
				if (!bert_run) begin
					st_d = spt_pkg::ST_IDLE;
				end
			end
			default: begin
				st_d = spt_pkg::ST_IDLE;
			end
		endcase
		if (bert_clear) begin
			st_d = spt_pkg::ST_IDLE;
		end
	end

	// seed beat counter, restarted whenever the sequencer leaves seeding
	assign seed_d = (st_q == spt_pkg::ST_SEED && i_lane.valid) ? seed_q + 5'h01 : 5'h00;

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= spt_pkg::ST_IDLE;
			seed_q <= 5'h00;
		end else begin
			st_q <= st_d;
			seed_q <= seed_d;
		end
	end

	wire checking = (st_q == spt_pkg::ST_CHECK);

	// ****************************************************************
	// per-lane checkers
	// ****************************************************************
	logic [LANES-1:0][23:0] lane_errors;

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [30:0] hist_q;
			logic [23:0] cnt_q;
			logic expect_bit;

			// predicted bit from the received history: x7+x6, x15+x14, x31+x28
			assign expect_bit = (pattern_selector == spt_pkg::PAT_PRBS7) ? hist_q[6] ^ hist_q[5] :
				(pattern_selector == spt_pkg::PAT_PRBS15) ? hist_q[14] ^ hist_q[13] :
				hist_q[30] ^ hist_q[27];
			wire bit_err = expect_bit ^ i_lane.bits[g];
			wire count_it = checking && lane_bert_enables_q[g] && i_lane.valid && bit_err;
			wire below_limit = cnt_q < bert_error_limit_q;

			// history shifts on every valid beat so it is ready on start
			always_ff @(posedge i_mclk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					hist_q <= 31'h00000000;
				end else if (i_lane.valid) begin
					hist_q <= {hist_q[29:0], i_lane.bits[g]};
				end
			end

			// counter holds when stopped and sticks at full scale
			always_ff @(posedge i_mclk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					cnt_q <= 24'h000000;
				end else if (bert_clear) begin
					cnt_q <= 24'h000000;
				end else if (count_it && (cnt_q != spt_pkg::ERR_MAX)) begin
					cnt_q <= cnt_q + 24'h000001;
				end
			end

			// pass flag follows the comparison while a test is live
			always_ff @(posedge i_mclk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					pass_q[g] <= spt_pkg::RST_PASS[g];
				end else if (bert_clear) begin
					pass_q[g] <= 1'b1;
				end else if (st_q != spt_pkg::ST_IDLE) begin
					pass_q[g] <= below_limit;
				end
			end

			assign lane_errors[g] = cnt_q;
		end
	endgenerate

	// readback source chosen by the lane selector
	wire [23:0] bert_error_total = lane_errors[error_lane_selector];

	// ****************************************************************
	// short transport test
	// ****************************************************************

	// sample taken straight from the receiver output, no later processing
	wire [15:0] picked_sample = i_tpl.samples[converter_selector][sample_selector];
	wire sample_differs = picked_sample != expected_sample_q;

	// clear beats a compare in the same cycle, as the clear is a level
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			transport_mismatch_q <= 1'b0;
		end else if (transport_result_clear) begin
			transport_mismatch_q <= 1'b0;
		end else if (transport_check_enable && i_tpl.valid) begin
			transport_mismatch_q <= sample_differs;
		end
	end

	// ****************************************************************
	// register readback
	// ****************************************************************

	// unmapped addresses read zero
	wire [7:0] rd_mux =
		(i_reg_addr == spt_pkg::OFF_LANE_BERT_EN) ? lane_bert_enables_q :
		(i_reg_addr == spt_pkg::OFF_PRBS_CTRL) ? prbs_ctrl_q :
		(i_reg_addr == spt_pkg::OFF_THR_LOW) ? bert_error_limit_q[7:0] :
		(i_reg_addr == spt_pkg::OFF_THR_MID) ? bert_error_limit_q[15:8] :
		(i_reg_addr == spt_pkg::OFF_THR_HIGH) ? bert_error_limit_q[23:16] :
		(i_reg_addr == spt_pkg::OFF_ERR_LOW) ? bert_error_total[7:0] :
		(i_reg_addr == spt_pkg::OFF_ERR_MID) ? bert_error_total[15:8] :
		(i_reg_addr == spt_pkg::OFF_ERR_HIGH) ? bert_error_total[23:16] :
		(i_reg_addr == spt_pkg::OFF_PASS_STATUS) ? pass_q :
		(i_reg_addr == spt_pkg::OFF_TPL_CTRL) ? tpl_ctrl_q :
		(i_reg_addr == spt_pkg::OFF_REF_LOW) ? expected_sample_q[7:0] :
		(i_reg_addr == spt_pkg::OFF_REF_HIGH) ? expected_sample_q[15:8] :
		(i_reg_addr == spt_pkg::OFF_TPL_RESULT) ? {7'h00, transport_mismatch_q} :
		8'h00;

	// read data is registered so it stays put between reads
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_q <= spt_pkg::RST_BYTE;
		end else if (i_reg_rd) begin
			rdata_q <= rd_mux;
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_lane_pass_flags = pass_q;
	assign o_transport_mismatch = transport_mismatch_q;

endmodule

// >>> spt_pkg.sv
// spt_pkg: constants and carrier types for the serdes self-test block
// assumes: 8-bit register port with 12-bit addresses, one 100 MHz clock
package spt_pkg;

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [11:0] OFF_LANE_BERT_EN = 12'h315;
	localparam logic [11:0] OFF_PRBS_CTRL = 12'h316;
	localparam logic [11:0] OFF_THR_LOW = 12'h317;
	localparam logic [11:0] OFF_THR_MID = 12'h318;
	localparam logic [11:0] OFF_THR_HIGH = 12'h319;
	localparam logic [11:0] OFF_ERR_LOW = 12'h31A;
	localparam logic [11:0] OFF_ERR_MID = 12'h31B;
	localparam logic [11:0] OFF_ERR_HIGH = 12'h31C;
	localparam logic [11:0] OFF_PASS_STATUS = 12'h31D;
	localparam logic [11:0] OFF_TPL_CTRL = 12'h32C;
	localparam logic [11:0] OFF_REF_LOW = 12'h32D;
	localparam logic [11:0] OFF_REF_HIGH = 12'h32E;
	localparam logic [11:0] OFF_TPL_RESULT = 12'h32F;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int CTRL_RUN_BIT = 1;
	localparam int CTRL_PAT_LSB = 2;
	localparam int CTRL_LANE_LSB = 4;
	localparam int TPL_EN_BIT = 0;
	localparam int TPL_CLR_BIT = 1;
	localparam int TPL_CONV_LSB = 2;
	localparam int TPL_SAMP_LSB = 4;
	localparam logic [7:0] CTRL_WR_MASK = 8'h7F;
	localparam logic [7:0] TPL_WR_MASK = 8'h3F;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_PASS = 8'hFF;

	// ****************************************************************
	// pattern codes and checker timing
	// ****************************************************************
	localparam logic [1:0] PAT_PRBS7 = 2'h0;
	localparam logic [1:0] PAT_PRBS15 = 2'h1;
	localparam logic [1:0] PAT_PRBS31 = 2'h2;
	// index of the last seed bit; 31 bits seed the longest checker before errors are counted
	localparam logic [4:0] SEED_LAST = 5'h1E;
	localparam logic [23:0] ERR_MAX = 24'hFFFFFF;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEED = 3'b010,
		ST_CHECK = 3'b100
	} spt_state_e;

	// one received bit per lane per beat from the deserialisers
	typedef struct packed {
		logic [7:0] bits;
		logic valid;
	} spt_lane_in_s;

	// converter samples at the link receiver output: [converter][sample]
	typedef struct packed {
		logic [3:0][3:0][15:0] samples;
		logic valid;
	} spt_tpl_in_s;

endpackage

// >>> spt_tx_model.sv
// spt_tx_model: link transmitter sending prbs lane bits and fixed samples
// assumes: bench clock, pattern chosen before each run is started
`timescale 1ns/100ps
module spt_tx_model (
	input wire logic i_clk,
	input wire logic [1:0] i_pat,
	input wire logic [7:0] i_flip,
	output spt_pkg::spt_lane_in_s o_lane,
	output spt_pkg::spt_tpl_in_s o_tpl
);
	// ****
	// lane pattern
	// ****
	logic [30:0] hist_q = 31'h7FFFFFFF;
	logic nbit;
	// same taps as the receiver, so only flips on the wire count as errors
	assign nbit = (i_pat == 2'h0) ? hist_q[6] ^ hist_q[5] :
		(i_pat == 2'h1) ? hist_q[14] ^ hist_q[13] : hist_q[30] ^ hist_q[27];
	always @(posedge i_clk) begin
		hist_q <= {hist_q[29:0], nbit};
	end
	// flips never enter our own history: a real transmitter stays clean
	assign o_lane.bits = {8{nbit}} ^ i_flip;
	assign o_lane.valid = 1'h1;
	// ****
	// converter samples, every slot distinct
	// ****
	for (genvar c = 0; c < 4; c++) begin : g_conv
		for (genvar s = 0; s < 4; s++) begin : g_samp
			assign o_tpl.samples[c][s] = {4'(c), 4'(s), 8'hC3};
		end
	end
	assign o_tpl.valid = 1'h1;
endmodule

// >>> spt_self_test_chk.sv
// spt_self_test_chk: port assertions for the self-test block
// assumes: bound to spt_self_test, one clock, async high reset
`timescale 1ns/100ps
module spt_self_test_chk (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic [11:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire spt_pkg::spt_lane_in_s i_lane,
	input wire spt_pkg::spt_tpl_in_s i_tpl,
	input wire logic [7:0] o_lane_pass_flags,
	input wire logic o_transport_mismatch
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// ****
	// shadow of transport setup
	// ****
	logic [5:0] tc_q;
	logic [5:0] tc2_q;
	logic [15:0] ref_q;
	wire wr_tc = i_reg_wr && i_reg_addr == 12'h32C;
	// delayed copy lets the disabled check skip the last live compare
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			tc_q <= 6'h00;
			tc2_q <= 6'h00;
			ref_q <= 16'h0000;
		end else begin
			tc2_q <= tc_q;
			if (wr_tc) begin
				tc_q <= i_reg_wdata[5:0];
			end
			if (i_reg_wr && i_reg_addr == 12'h32D) begin
				ref_q[7:0] <= i_reg_wdata;
			end
			if (i_reg_wr && i_reg_addr == 12'h32E) begin
				ref_q[15:8] <= i_reg_wdata;
			end
		end
	end
	// ****
	// properties
	// ****
	sequence s_ctrl_wr;
		i_reg_wr && i_reg_addr == 12'h316;
	endsequence
	sequence s_ctrl_rd;
		i_reg_rd && !i_reg_wr && i_reg_addr == 12'h316;
	endsequence
	sequence s_tpl_steady;
		(tc_q[0] && !tc_q[1] && i_tpl.valid && !i_reg_wr) [*3];
	endsequence
	AST_RST_FLAGS: assert property ($fell(i_sys_rst) |-> o_lane_pass_flags == 8'hFF && !o_transport_mismatch)
		else $error("outputs wrong after reset");
	AST_RES_ZERO: assert property (i_reg_rd && i_reg_addr == 12'h32F |=> o_reg_rdata[7:1] == 7'h00)
		else $error("result reserved bits set");
	AST_STAT_RD: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 12'h31D |=> o_reg_rdata == $past(o_lane_pass_flags))
		else $error("status read differs from flags");
	AST_CTRL_RB: assert property (s_ctrl_wr ##1 s_ctrl_rd |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'h7F))
		else $error("control readback wrong");
	AST_BERT_CLR: assert property (s_ctrl_wr and i_reg_wdata[0] |-> ##[1:3] o_lane_pass_flags == 8'hFF)
		else $error("clear did not set pass flags");
	AST_TPL_CLR: assert property (wr_tc && i_reg_wdata[1] |-> ##[1:3] !o_transport_mismatch)
		else $error("transport clear ignored");
	AST_TPL_OFF: assert property (!tc_q[0] && !tc2_q[0] && !tc_q[1] && !tc2_q[1] |=> $stable(o_transport_mismatch))
		else $error("result moved while disabled");
	AST_TPL_CMP: assert property (s_tpl_steady |-> o_transport_mismatch == (i_tpl.samples[tc_q[3:2]][tc_q[5:4]] != ref_q))
		else $error("transport compare wrong");
	AST_RD_HOLD: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data moved without a read");
endmodule

// >>> spt_self_test_tb.sv
// spt_self_test_tb: register-driven checks of bit-error and transport tests
// assumes: spt_tx_model on the lanes, inputs driven 1 ns after each edge
`timescale 1ns/100ps
module spt_self_test_tb;
	logic i_mclk = 1'h0;
	logic i_sys_rst = 1'h1;
	logic [11:0] addr = 12'h000;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [7:0] wd = 8'h00;
	logic [1:0] pat = 2'h0;
	logic [7:0] flip = 8'h00;
	logic [7:0] rdata;
	logic [7:0] pass;
	logic mism;
	logic [7:0] v;
	int err_count = 0;
	int total_checks = 0;
	spt_pkg::spt_lane_in_s lane;
	spt_pkg::spt_tpl_in_s tpl;
	always #5 i_mclk = ~i_mclk;
	spt_self_test #(.LANES(8)) spt_self_test_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_lane(lane), .i_tpl(tpl),
		.o_lane_pass_flags(pass), .o_transport_mismatch(mism));
	spt_tx_model spt_tx_model_inst (.i_clk(i_mclk), .i_pat(pat), .i_flip(flip), .o_lane(lane), .o_tpl(tpl));
	// ****
	// access tasks
	// ****
	// strobes stay up until the next call, so back-to-back never double-drives
	task automatic acc(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
		wr = w;
		rd = r;
		addr = a;
		wd = d;
		@(posedge i_mclk);
		#1;
		v = rdata;
	endtask
	task automatic idle(input int n);
		wr = 1'h0;
		rd = 1'h0;
		repeat (n) begin
			@(posedge i_mclk);
			#1;
		end
	endtask
	task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", n, e, s);
		end
	endtask
	// selecting a lane rewrites control with run low, so the test stops
	task automatic cnt(input logic [2:0] ln, input logic [23:0] e);
		logic [23:0] c;
		acc(1'h1, 1'h0, 12'h316, {1'h0, ln, pat, 2'h0});
		for (int i = 0; i < 3; i++) begin
			acc(1'h0, 1'h1, 12'h31A + 12'(i), 8'h00);
			c[8*i +: 8] = v;
		end
		chk("errcnt", c, e);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ****
	// tests
	// ****
	// about 500 cycles expected, ten times that allowed
	initial begin
		#50000;
		err_count++;
		give_verdict();
	end
	initial begin
		repeat (20) @(posedge i_mclk);
		#1;
		i_sys_rst = 1'h0;
		// whole map after reset, holes included
		for (int a = 12'h315; a <= 12'h32F; a++) begin
			acc(1'h0, 1'h1, 12'(a), 8'h00);
			chk("reset", v, (a == 12'h31D) ? 8'hFF : 8'h00);
		end
		acc(1'h1, 1'h0, 12'h316, 8'hFC);
		acc(1'h0, 1'h1, 12'h316, 8'h00);
		chk("ctrl", v, 8'h7C);
		acc(1'h1, 1'h0, 12'h31D, 8'h00);
		acc(1'h0, 1'h1, 12'h31D, 8'h00);
		chk("status", v, 8'hFF);
		for (int i = 0; i < 3; i++) begin
			acc(1'h1, 1'h0, 12'h317 + 12'(i), 8'h3C + 8'(i));
			acc(1'h0, 1'h1, 12'h317 + 12'(i), 8'h00);
			chk("limit", v, 8'h3C + 8'(i));
		end
		acc(1'h1, 1'h0, 12'h317, 8'h03);
		acc(1'h1, 1'h0, 12'h318, 8'h00);
		acc(1'h1, 1'h0, 12'h319, 8'h00);
		acc(1'h1, 1'h0, 12'h315, 8'hDF);
		acc(1'h0, 1'h1, 12'h315, 8'h00);
		chk("enables", v, 8'hDF);
		$display("registers done");
		// each isolated flip costs three errors: the bit and its two taps
		for (int p = 0; p < 3; p++) begin
			pat = 2'(p);
			acc(1'h1, 1'h0, 12'h316, 8'h01);
			idle(3);
			acc(1'h0, 1'h1, 12'h31D, 8'h00);
			chk("pass clr", v, 8'hFF);
			cnt(3'h3, 24'h0);
			acc(1'h1, 1'h0, 12'h316, {4'h0, pat, 2'h2});
			idle(40);
			flip = 8'h28;
			idle(1);
			flip = 8'h00;
			idle(40);
			chk("pass", pass, 8'hF7);
			cnt(3'h3, 24'h3);
			cnt(3'h5, 24'h0);
			flip = 8'h08;
			idle(1);
			flip = 8'h00;
			idle(10);
			cnt(3'h3, 24'h3);
			$display("pattern %0d done", p);
		end
		acc(1'h1, 1'h0, 12'h32D, 8'hC3);
		acc(1'h1, 1'h0, 12'h32E, 8'h21);
		for (int c = 0; c < 4; c++) begin
			for (int s = 0; s < 4; s++) begin
				acc(1'h1, 1'h0, 12'h32C, {2'h0, 2'(s), 2'(c), 2'h1});
				idle(3);
				acc(1'h0, 1'h1, 12'h32F, 8'h00);
				chk("tpl", v, {7'h0, !(c == 2 && s == 1)});
				chk("tpl pin", mism, !(c == 2 && s == 1));
			end
		end
		acc(1'h1, 1'h0, 12'h32C, 8'h3E);
		idle(3);
		acc(1'h0, 1'h1, 12'h32F, 8'h00);
		chk("tpl clr", v, 8'h00);
		acc(1'h1, 1'h0, 12'h32C, 8'h3C);
		idle(3);
		acc(1'h0, 1'h1, 12'h32F, 8'h00);
		chk("tpl off", v, 8'h00);
		chk("tpl pin", mism, 1'h0);
		$display("transport done");
		// leave a failing result and a failed lane behind, then reset in mid-run
		acc(1'h1, 1'h0, 12'h32C, 8'h3D);
		idle(2);
		chk("tpl set", mism, 1'h1);
		i_sys_rst = 1'h1;
		idle(2);
		i_sys_rst = 1'h0;
		chk("rst pins", {mism, pass}, 9'h0FF);
		acc(1'h0, 1'h1, 12'h31D, 8'h00);
		chk("rst status", v, 8'hFF);
		acc(1'h0, 1'h1, 12'h32C, 8'h00);
		chk("rst tpl ctrl", v, 8'h00);
		acc(1'h0, 1'h1, 12'h32F, 8'h00);
		chk("rst tpl result", v, 8'h00);
		$display("reset done");
		give_verdict();
	end
endmodule
bind spt_self_test spt_self_test_chk spt_self_test_chk_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
	.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .i_lane(i_lane), .i_tpl(i_tpl), .o_lane_pass_flags(o_lane_pass_flags),
	.o_transport_mismatch(o_transport_mismatch));
